// >>> rqd_pkg.sv
// Purpose: Shared constants for the request descriptor host controller
// Assumes: 64-bit request stream, 32-bit classic Wishbone register port
// Notes:   Offsets are byte addresses; each register is one aligned word
package rqd_pkg;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned DESC_W = 128;
  localparam int unsigned WB_AW  = 8;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0c;
  localparam logic [7:0] OFS_REQ     = 8'h10;
  localparam logic [7:0] OFS_ID      = 8'h14;
  localparam logic [7:0] OFS_TARGET  = 8'h18;
  localparam logic [7:0] OFS_DATA0   = 8'h1c;
  localparam logic [7:0] OFS_DATA1   = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_TEN_BIT = 1;
  localparam int unsigned CTRL_ROOT    = 2;
  localparam int unsigned CTRL_RELAY   = 3;
  localparam int unsigned CTRL_ADDR64  = 4;
  localparam int unsigned CTRL_ZLEN    = 5;
  localparam int unsigned CTRL_POSTED  = 6;
  localparam int unsigned CTRL_POISON  = 7;
  localparam int unsigned CTRL_ARI     = 8;
  localparam int unsigned CTRL_CLS_LO  = 9;
  localparam int unsigned CTRL_PAYLOAD = 11;
  localparam int unsigned CTRL_W       = 12;

  // Request class, chooses which descriptor fields apply
  localparam logic [1:0] CLS_MEM = 2'h0;
  localparam logic [1:0] CLS_IO  = 2'h1;
  localparam logic [1:0] CLS_CFG = 2'h2;
  localparam logic [1:0] CLS_MSG = 2'h3;

  // Descriptor field positions
  localparam int unsigned D_AT_LO    = 0;
  localparam int unsigned D_ADDR_LO  = 2;
  localparam int unsigned D_CNT_LO   = 64;
  localparam int unsigned D_TYPE_LO  = 75;
  localparam int unsigned D_POISON   = 79;
  localparam int unsigned D_FN_LO    = 80;
  localparam int unsigned D_BUS_LO   = 88;
  localparam int unsigned D_TAG_LO   = 96;
  localparam int unsigned D_TGT_LO   = 104;
  localparam int unsigned D_SRC_SEL  = 120;
  localparam int unsigned D_TC_LO    = 121;
  localparam int unsigned D_ATTR_LO  = 124;
  localparam int unsigned D_TAG_B    = 127;

  localparam logic [10:0] CNT_ONE  = 11'h001;
  localparam logic [1:0]  KEEP_ALL = 2'h3;
  localparam logic [1:0]  KEEP_LO  = 2'h1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : rqd_pkg

// >>> rqd_desc_pack.sv
// Purpose: Packs request fields into the 16-byte descriptor
// Assumes: Fields come from stable software registers
// Notes:   Fields that do not apply to the class are forced to zero
module rqd_desc_pack (
  input  wire logic [1:0]   cls_i,
  input  wire logic         addr64_i,
  input  wire logic         zlen_i,
  input  wire logic         posted_i,
  input  wire logic         poison_i,
  input  wire logic         ari_i,
  input  wire logic         root_i,
  input  wire logic         relay_i,
  input  wire logic         ten_bit_i,
  input  wire logic [31:0]  addr_lo_i,
  input  wire logic [31:0]  addr_hi_i,
  input  wire logic [31:0]  req_i,
  input  wire logic [31:0]  id_i,
  input  wire logic [15:0]  target_i,
  output logic      [127:0] desc_o,
  output logic      [7:0]   masks_o
);
  logic ext_id;
  logic is_mem;
  logic [10:0] cnt;

  always_comb begin
    ext_id = root_i | relay_i;
    is_mem = (cls_i == rqd_pkg::CLS_MEM);
    cnt    = req_i[10:0];
    if ((cls_i == rqd_pkg::CLS_IO) || zlen_i) begin
      cnt = rqd_pkg::CNT_ONE;
    end
    desc_o = '0;
    if (is_mem) begin
      desc_o[rqd_pkg::D_AT_LO +: 2] = req_i[22:21];
    end
    if (cls_i != rqd_pkg::CLS_CFG) begin
      // Messages reuse this area for destination ID and vendor header
      desc_o[rqd_pkg::D_ADDR_LO +: 30] = addr_lo_i[31:2];
      if (cls_i == rqd_pkg::CLS_MSG) begin
        desc_o[1:0]   = addr_lo_i[1:0];
        desc_o[63:32] = addr_hi_i;
      end else if (addr64_i) begin
        desc_o[63:32] = addr_hi_i;
      end
    end
    desc_o[rqd_pkg::D_CNT_LO +: 11] = cnt;
    desc_o[rqd_pkg::D_TYPE_LO +: 4] = req_i[14:11];
    desc_o[rqd_pkg::D_POISON]       = poison_i;
    if (ari_i) begin
      desc_o[rqd_pkg::D_FN_LO +: 8] = id_i[7:0];
    end else begin
      desc_o[rqd_pkg::D_FN_LO +: 3] = id_i[2:0];
      desc_o[rqd_pkg::D_FN_LO + 3 +: 5] = ext_id ? id_i[7:3] : 5'h00;
    end
    desc_o[rqd_pkg::D_BUS_LO +: 8] = ext_id ? id_i[15:8] : 8'h00;
    desc_o[rqd_pkg::D_TAG_LO +: 8] = id_i[23:16];
    if ((cls_i == rqd_pkg::CLS_CFG) || (cls_i == rqd_pkg::CLS_MSG)) begin
      desc_o[rqd_pkg::D_TGT_LO +: 16] = target_i;
    end
    if (ten_bit_i) begin
      desc_o[rqd_pkg::D_SRC_SEL] = posted_i ? 1'b0 : id_i[24];
      desc_o[rqd_pkg::D_TAG_B]   = posted_i ? 1'b0 : id_i[25];
    end else begin
      desc_o[rqd_pkg::D_SRC_SEL] = ext_id;
    end
    desc_o[rqd_pkg::D_TC_LO +: 3]  = req_i[17:15];
    desc_o[rqd_pkg::D_ATTR_LO +: 2] = req_i[19:18];
    desc_o[rqd_pkg::D_ATTR_LO + 2] = (is_mem || (cls_i == rqd_pkg::CLS_MSG)) & req_i[20];
    masks_o = zlen_i ? 8'h00 : {req_i[30:27], req_i[26:23]};
  end
endmodule // rqd_desc_pack

// >>> rqd_host.sv
// Purpose: Host controller that issues request packets on a 64-bit stream
// Assumes: Software programs fields over classic Wishbone, then sets start
// Notes:   Payload is at most one beat (two dwords) taken from data registers
// How it works
// - Each request goes out as its own packet, descriptor first, payload after.
// - Descriptor is exactly sixteen bytes and fills the packet's first sixteen bytes.
// - On a 64-bit path the descriptor takes two beats.
// - Bits 63:2 carry dword address; upper word zero for 32-bit addresses.
// - Dword count at 74:64, forced to one for I/O accesses.
// - Zero-length access sends count one with all first byte mask bits zero.
// - Bits 78:75 carry the request type code.
// - Poison bit 79 only set when software asks for a poisoned request.
// - Bits 87:80 carry function, or device plus function without ARI; device bits 87:83 driven only for root port or relayed requests.
// - Bus number bits 95:88 driven only for root port or relayed requests.
// - Completer ID at 119:104 for configuration and ID-routed messages.
// - Bit 120 zero for endpoint own requests, one for root or relay; with ten-bit tags it carries an upper tag bit instead.
// - Bit 127 carries a second upper tag bit; zero for posted requests.
// - Bits 123:121 carry the traffic class.
// - ID-routed vendor messages put destination ID at bits 15:0.
// - Valid stays high for the whole packet; beats hold while stalled.
module rqd_host (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [rqd_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [31:0]                wb_dat_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic                       wb_we_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  output logic      [rqd_pkg::DATA_W-1:0] rq_tdata_o,
  output logic      [1:0]                 rq_tkeep_o,
  output logic                            rq_tlast_o,
  output logic                            request_stream_valid_o,
  output logic      [7:0]                 request_sideband_bus_o,
  input  wire logic                       rq_tready_i
);
  typedef enum logic [1:0] {ST_IDLE, ST_DESC_LO, ST_DESC_HI, ST_PAYLOAD} rqd_state_e;

  // Register file
  logic [rqd_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [31:0] addr_lo_r, addr_lo_nxt, addr_hi_r, addr_hi_nxt;
  logic [31:0] req_r, req_nxt, id_r, id_nxt;
  logic [15:0] target_r, target_nxt;
  logic [31:0] data0_r, data0_nxt, data1_r, data1_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic        ack_r, ack_nxt;
  logic        start_r, start_nxt;
  logic [31:0] wmask;
  logic        wb_hit;

  // Stream engine
  rqd_state_e  state_r, state_nxt;
  logic [rqd_pkg::DESC_W-1:0] desc_r, desc_nxt;
  logic [63:0] pay_r, pay_nxt;
  logic        with_pay_r, with_pay_nxt;
  logic [1:0]  pay_keep_r, pay_keep_nxt;
  logic [7:0]  sent_r, sent_nxt;
  logic [63:0] tdata_r, tdata_nxt;
  logic [1:0]  tkeep_r, tkeep_nxt;
  logic        tlast_r, tlast_nxt;
  logic        tvalid_r, tvalid_nxt;
  logic [7:0]  side_r, side_nxt;
  logic [rqd_pkg::CTRL_W-1:0] ctrl_l_r, ctrl_l_nxt;
  logic [127:0] desc_w;
  logic [7:0]   masks_w;
  logic         busy;
  logic         beat_done;

  assign busy      = (state_r != ST_IDLE);
  assign beat_done = tvalid_r & rq_tready_i;

  rqd_desc_pack u_pack (
    .cls_i     (ctrl_r[rqd_pkg::CTRL_CLS_LO +: 2]),
    .addr64_i  (ctrl_r[rqd_pkg::CTRL_ADDR64]),
    .zlen_i    (ctrl_r[rqd_pkg::CTRL_ZLEN]),
    .posted_i  (ctrl_r[rqd_pkg::CTRL_POSTED]),
    .poison_i  (ctrl_r[rqd_pkg::CTRL_POISON]),
    .ari_i     (ctrl_r[rqd_pkg::CTRL_ARI]),
    .root_i    (ctrl_r[rqd_pkg::CTRL_ROOT]),
    .relay_i   (ctrl_r[rqd_pkg::CTRL_RELAY]),
    .ten_bit_i (ctrl_r[rqd_pkg::CTRL_TEN_BIT]),
    .addr_lo_i (addr_lo_r),
    .addr_hi_i (addr_hi_r),
    .req_i     (req_r),
    .id_i      (id_r),
    .target_i  (target_r),
    .desc_o    (desc_w),
    .masks_o   (masks_w)
  );

  // Wishbone slave: one wait state, ack drops the cycle after it was given
  always_comb begin
    wb_hit     = wb_cyc_i & wb_stb_i & ~ack_r;
    wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    ctrl_nxt   = ctrl_r;
    addr_lo_nxt = addr_lo_r;
    addr_hi_nxt = addr_hi_r;
    req_nxt    = req_r;
    id_nxt     = id_r;
    target_nxt = target_r;
    data0_nxt  = data0_r;
    data1_nxt  = data1_r;
    start_nxt  = 1'b0;
    ack_nxt    = wb_hit;
    rdat_nxt   = rqd_pkg::RST_WORD;
    ctrl_nxt[rqd_pkg::CTRL_START] = 1'b0;
    if (wb_hit && wb_we_i) begin
      unique case (wb_adr_i)
        rqd_pkg::OFS_CTRL: begin
          ctrl_nxt = (ctrl_r & ~wmask[rqd_pkg::CTRL_W-1:0])
                   | (wb_dat_i[rqd_pkg::CTRL_W-1:0] & wmask[rqd_pkg::CTRL_W-1:0]);
          // A start while a packet is in flight is dropped
          start_nxt = wb_sel_i[0] & wb_dat_i[rqd_pkg::CTRL_START] & ~busy;
          ctrl_nxt[rqd_pkg::CTRL_START] = 1'b0;
        end
        rqd_pkg::OFS_ADDR_LO: addr_lo_nxt = (addr_lo_r & ~wmask) | (wb_dat_i & wmask);
        rqd_pkg::OFS_ADDR_HI: addr_hi_nxt = (addr_hi_r & ~wmask) | (wb_dat_i & wmask);
        rqd_pkg::OFS_REQ:     req_nxt     = (req_r & ~wmask) | (wb_dat_i & wmask);
        rqd_pkg::OFS_ID:      id_nxt      = (id_r & ~wmask) | (wb_dat_i & wmask);
        rqd_pkg::OFS_TARGET:  target_nxt  = (target_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        rqd_pkg::OFS_DATA0:   data0_nxt   = (data0_r & ~wmask) | (wb_dat_i & wmask);
        rqd_pkg::OFS_DATA1:   data1_nxt   = (data1_r & ~wmask) | (wb_dat_i & wmask);
        default: ;
      endcase
    end
    if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        rqd_pkg::OFS_CTRL:    rdat_nxt = {20'h00000, ctrl_r};
        rqd_pkg::OFS_STATUS:  rdat_nxt = {16'h0000, sent_r, 7'h00, busy};
        rqd_pkg::OFS_ADDR_LO: rdat_nxt = addr_lo_r;
        rqd_pkg::OFS_ADDR_HI: rdat_nxt = addr_hi_r;
        rqd_pkg::OFS_REQ:     rdat_nxt = req_r;
        rqd_pkg::OFS_ID:      rdat_nxt = id_r;
        rqd_pkg::OFS_TARGET:  rdat_nxt = {16'h0000, target_r};
        rqd_pkg::OFS_DATA0:   rdat_nxt = data0_r;
        rqd_pkg::OFS_DATA1:   rdat_nxt = data1_r;
        default:              rdat_nxt = rqd_pkg::RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= '0;
      addr_lo_r <= rqd_pkg::RST_WORD;
      addr_hi_r <= rqd_pkg::RST_WORD;
      req_r    <= rqd_pkg::RST_WORD;
      id_r     <= rqd_pkg::RST_WORD;
      target_r <= 16'h0000;
      data0_r  <= rqd_pkg::RST_WORD;
      data1_r  <= rqd_pkg::RST_WORD;
      rdat_r   <= rqd_pkg::RST_WORD;
      ack_r    <= 1'b0;
      start_r  <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      addr_lo_r <= addr_lo_nxt;
      addr_hi_r <= addr_hi_nxt;
      req_r    <= req_nxt;
      id_r     <= id_nxt;
      target_r <= target_nxt;
      data0_r  <= data0_nxt;
      data1_r  <= data1_nxt;
      rdat_r   <= rdat_nxt;
      ack_r    <= ack_nxt;
      start_r  <= start_nxt;
    end
  end

  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;

  // Stream engine: descriptor is latched whole so later register writes
  // cannot tear a packet already on the wire
  always_comb begin
    state_nxt    = state_r;
    desc_nxt     = desc_r;
    pay_nxt      = pay_r;
    with_pay_nxt = with_pay_r;
    pay_keep_nxt = pay_keep_r;
    ctrl_l_nxt   = ctrl_l_r;
    sent_nxt     = sent_r;
    tdata_nxt    = tdata_r;
    tkeep_nxt    = tkeep_r;
    tlast_nxt    = tlast_r;
    tvalid_nxt   = tvalid_r;
    side_nxt     = side_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_r) begin
          desc_nxt     = desc_w;
          ctrl_l_nxt   = ctrl_r;
          pay_nxt      = {data1_r, data0_r};
          with_pay_nxt = ctrl_r[rqd_pkg::CTRL_PAYLOAD];
          // Zero-length write still carries one dummy dword
          pay_keep_nxt = (ctrl_r[rqd_pkg::CTRL_ZLEN] || (desc_w[74:64] == rqd_pkg::CNT_ONE))
                         ? rqd_pkg::KEEP_LO : rqd_pkg::KEEP_ALL;
          tdata_nxt    = desc_w[63:0];
          tkeep_nxt    = rqd_pkg::KEEP_ALL;
          tlast_nxt    = 1'b0;
          tvalid_nxt   = 1'b1;
          side_nxt     = masks_w;
          state_nxt    = ST_DESC_LO;
        end
      end
      ST_DESC_LO: begin
        if (rq_tready_i) begin
          tdata_nxt = desc_r[127:64];
          side_nxt  = 8'h00;
          tlast_nxt = ~with_pay_r;
          state_nxt = ST_DESC_HI;
        end
      end
      ST_DESC_HI: begin
        if (rq_tready_i) begin
          if (with_pay_r) begin
            tdata_nxt = pay_r;
            tkeep_nxt = pay_keep_r;
            tlast_nxt = 1'b1;
            state_nxt = ST_PAYLOAD;
          end else begin
            tvalid_nxt = 1'b0;
            tlast_nxt  = 1'b0;
            sent_nxt   = sent_r + 8'h01;
            state_nxt  = ST_IDLE;
          end
        end
      end
      ST_PAYLOAD: begin
        if (rq_tready_i) begin
          tvalid_nxt = 1'b0;
          tlast_nxt  = 1'b0;
          tkeep_nxt  = rqd_pkg::KEEP_ALL;
          sent_nxt   = sent_r + 8'h01;
          state_nxt  = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ST_IDLE;
      desc_r     <= '0;
      pay_r      <= 64'h0;
      with_pay_r <= 1'b0;
      pay_keep_r <= rqd_pkg::KEEP_ALL;
      ctrl_l_r   <= '0;
      sent_r     <= 8'h00;
      tdata_r    <= 64'h0;
      tkeep_r    <= rqd_pkg::KEEP_ALL;
      tlast_r    <= 1'b0;
      tvalid_r   <= 1'b0;
      side_r     <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      desc_r     <= desc_nxt;
      pay_r      <= pay_nxt;
      with_pay_r <= with_pay_nxt;
      pay_keep_r <= pay_keep_nxt;
      ctrl_l_r   <= ctrl_l_nxt;
      sent_r     <= sent_nxt;
      tdata_r    <= tdata_nxt;
      tkeep_r    <= tkeep_nxt;
      tlast_r    <= tlast_nxt;
      tvalid_r   <= tvalid_nxt;
      side_r     <= side_nxt;
    end
  end

  assign rq_tdata_o             = tdata_r;
  assign rq_tkeep_o             = tkeep_r;
  assign rq_tlast_o             = tlast_r;
  assign request_stream_valid_o = tvalid_r;
  assign request_sideband_bus_o = side_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_valid_held: assert property (tvalid_r && !(rq_tready_i && tlast_r) |=> tvalid_r)
    else $error("valid dropped inside a packet");
  a_beat_stable: assert property (tvalid_r && !rq_tready_i |=> $stable(tdata_r) && $stable(tlast_r)
                                  && $stable(tkeep_r))
    else $error("beat changed while stalled");
  a_desc_two_beats: assert property (start_r && state_r == ST_IDLE
                                     |=> tvalid_r && !tlast_r && tdata_r == desc_r[63:0])
    else $error("descriptor first beat wrong");
  a_upper_addr_zero: assert property (state_r == ST_DESC_LO && !ctrl_l_r[rqd_pkg::CTRL_ADDR64]
      && ctrl_l_r[10:9] != rqd_pkg::CLS_MSG |-> tdata_r[63:32] == 32'h0)
    else $error("upper address not zero for 32-bit address");
  a_io_count_one: assert property (state_r == ST_DESC_HI && ctrl_l_r[10:9] == rqd_pkg::CLS_IO
                                   |-> tdata_r[10:0] == rqd_pkg::CNT_ONE)
    else $error("I/O dword count not one");
  a_zero_len_mask: assert property (state_r == ST_DESC_LO && ctrl_l_r[rqd_pkg::CTRL_ZLEN]
      |-> side_r[3:0] == 4'h0 && desc_r[74:64] == rqd_pkg::CNT_ONE)
    else $error("zero-length request malformed");
  a_poison_clear: assert property (state_r == ST_DESC_HI && !ctrl_l_r[rqd_pkg::CTRL_POISON]
                                   |-> !tdata_r[15])
    else $error("poison set without request");
  a_posted_tag_b: assert property (state_r == ST_DESC_HI && ctrl_l_r[rqd_pkg::CTRL_POSTED]
                                   |-> !tdata_r[63])
    else $error("upper tag bit set on posted request");
  a_endpoint_src: assert property (state_r == ST_DESC_HI && !ctrl_l_r[rqd_pkg::CTRL_TEN_BIT]
      && !ctrl_l_r[rqd_pkg::CTRL_ROOT] && !ctrl_l_r[rqd_pkg::CTRL_RELAY]
      |-> !tdata_r[56] && tdata_r[31:24] == 8'h0
      && (ctrl_l_r[rqd_pkg::CTRL_ARI] || tdata_r[23:19] == 5'h0))
    else $error("endpoint requester source fields wrong");

  c_read_done: cover property (state_r == ST_DESC_HI && rq_tready_i && !with_pay_r);
  c_write_done: cover property (state_r == ST_PAYLOAD && rq_tready_i);
  c_stall_desc: cover property (state_r == ST_DESC_LO && !rq_tready_i ##1 rq_tready_i);
endmodule // rqd_host

// >>> rqd_dev_model.sv
// Purpose: Behavioural sink for the requester request stream
// Assumes: 64-bit stream, descriptor in the first two beats
// Notes:   Header fields are kept as given; protocol faults are counted
module rqd_dev_model (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [63:0]  tdata_i,
  input  wire logic [1:0]   tkeep_i,
  input  wire logic         tlast_i,
  input  wire logic         valid_i,
  input  wire logic [7:0]   side_i,
  input  wire logic         stall_i,
  output logic              tready_o,
  output logic      [127:0] desc_o,
  output logic      [7:0]   masks_o,
  output logic      [63:0]  data_o,
  output logic      [1:0]   keep_o,
  output logic      [1:0]   beats_o,
  output logic      [7:0]   pkts_o,
  output logic      [7:0]   errs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  beat_r;
  logic        busy_r;
  logic        hold_r;
  logic        tick_r;
  logic [66:0] held_r;
  logic        bad;
  // Slow mode accepts every other cycle so stalls land mid-packet
  assign tready_o = !stall_i | tick_r;
  // A gap in valid would nullify the request on the link
  assign bad = (busy_r && !valid_i)
            || (hold_r && valid_i && {tdata_i, tkeep_i, tlast_i} !== held_r)
            || (valid_i && beat_r != 2'h0 && side_i != 8'h00)
            || (valid_i && beat_r < 2'h2 && tkeep_i != 2'h3);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      beat_r <= 2'h0;
      busy_r <= 1'b0;
      hold_r <= 1'b0;
      tick_r <= 1'b0;
      pkts_o <= 8'h00;
      errs_o <= 8'h00;
    end else begin
      tick_r <= !tick_r;
      hold_r <= valid_i && !tready_o;
      held_r <= {tdata_i, tkeep_i, tlast_i};
      if (bad) errs_o <= errs_o + 8'h01;
      if (valid_i && tready_o) begin
        beat_r <= tlast_i ? 2'h0 : beat_r + 2'h1;
        busy_r <= !tlast_i;
        // Count is never checked against payload; all attributes enabled
        case (beat_r)
          2'h0: begin
            desc_o[63:0] <= tdata_i;
            masks_o      <= side_i;
          end
          2'h1: desc_o[127:64] <= tdata_i;
          default: begin
            data_o <= tdata_i;
            keep_o <= tkeep_i;
          end
        endcase
        if (tlast_i) begin
          beats_o <= beat_r + 2'h1;
          pkts_o  <= pkts_o + 8'h01;
        end
      end
    end
  end
endmodule // rqd_dev_model

// >>> rqd_tb.sv
// Purpose: Self-checking bench for the request descriptor host controller
// Assumes: Wishbone acks on the second clock of each access (checked as wb_wait); sink may stall
// Notes:   Expected descriptors are rebuilt from the programmed registers
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk;
  logic         rst = 1'b1;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0;
  logic [3:0]   sel = 4'h0;
  logic         we = 1'b0;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         stall = 1'b0;
  logic [3:0]   wsel = 4'hf;
  logic [31:0]  rdat;
  logic         ack;
  logic [63:0]  tdata;
  logic [1:0]   tkeep;
  logic         tlast;
  logic         tvalid;
  logic [7:0]   side;
  logic         tready;
  logic [127:0] desc;
  logic [7:0]   masks;
  logic [63:0]  pdata;
  logic [1:0]   pkeep;
  logic [1:0]   beats;
  logic [7:0]   pkts;
  logic [7:0]   errs;
  logic [31:0]  s;
  int           miscompares = 0;
  int           tests_run = 0;
  int           cycles = 0;
  logic [31:0] t_ctrl [6] = '{32'h010, 32'h9c2, 32'ha04, 32'h028, 32'h402, 32'h640};
  logic [31:0] t_alo [6] = '{32'h1234567c, 32'h89abcdf0, 32'h00000cf8, 32'h00400000,
                             32'h55555554, 32'h00004321};
  logic [31:0] t_ahi [6] = '{32'h000000ab, 32'h00000077, 32'h0, 32'h0, 32'h0000ffff,
                             32'hcafef00d};
  logic [31:0] t_req [6] = '{32'h7fde8100, 32'h1f8c0802, 32'h01b09005, 32'h7f800010,
                             32'h07802001, 32'h0013e000};
  logic [31:0] t_id [6] = '{32'h035a773d, 32'h03119af5, 32'h00c6a4b3, 32'h0002ff0e,
                            32'h03c40002, 32'h03e80a09};
  logic [31:0] t_tgt [6] = '{32'hbeef, 32'h1111, 32'h2222, 32'h3333, 32'h1208, 32'h027e};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  rqd_host u_dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rq_tdata_o(tdata), .rq_tkeep_o(tkeep), .rq_tlast_o(tlast),
    .request_stream_valid_o(tvalid), .request_sideband_bus_o(side), .rq_tready_i(tready));

  rqd_dev_model u_dev (.clk_i(clk), .rst_i(rst), .tdata_i(tdata), .tkeep_i(tkeep),
    .tlast_i(tlast), .valid_i(tvalid), .side_i(side), .stall_i(stall), .tready_o(tready),
    .desc_o(desc), .masks_o(masks), .data_o(pdata), .keep_o(pkeep), .beats_o(beats),
    .pkts_o(pkts), .errs_o(errs));

  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= wsel;
    cyc <= 1'b1;
    stb <= 1'b1;
    // No local limit: a missing ack is ended by the cycle watchdog
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check("wb_wait", n, 2);
  endtask

  // Descriptor as the controller should build it from its registers
  function automatic logic [127:0] exp_desc(input logic [31:0] c, al, ah, r, id, tg);
    logic [127:0] d;
    logic [1:0]   k;
    logic         rr;
    k = c[10:9];
    rr = c[2] | c[3];
    d = '0;
    if (k == rqd_pkg::CLS_MSG) d[63:0] = {ah, al};
    else if (k != rqd_pkg::CLS_CFG) d[63:2] = {c[4] ? ah : 32'h0, al[31:2]};
    if (k == rqd_pkg::CLS_MEM) d[1:0] = r[22:21];
    d[74:64] = (k == rqd_pkg::CLS_IO || c[5]) ? 11'h001 : r[10:0];
    d[79:75] = {c[7], r[14:11]};
    d[87:80] = c[8] ? id[7:0] : {rr ? id[7:3] : 5'h00, id[2:0]};
    d[95:88] = rr ? id[15:8] : 8'h00;
    d[103:96] = id[23:16];
    if (k == rqd_pkg::CLS_CFG || k == rqd_pkg::CLS_MSG) d[119:104] = tg[15:0];
    d[120] = c[1] ? (!c[6] & id[24]) : rr;
    d[123:121] = r[17:15];
    d[126:124] = {(k == rqd_pkg::CLS_MEM || k == rqd_pkg::CLS_MSG) & r[20], r[19:18]};
    d[127] = c[1] & !c[6] & id[25];
    return d;
  endfunction

  task automatic run_case(input int i);
    logic [127:0] d;
    d = exp_desc(t_ctrl[i], t_alo[i], t_ahi[i], t_req[i], t_id[i], t_tgt[i]);
    stall <= !i[0];
    wb_xfer(rqd_pkg::OFS_ADDR_LO, 1'b1, t_alo[i], s);
    wb_xfer(rqd_pkg::OFS_ADDR_HI, 1'b1, t_ahi[i], s);
    wb_xfer(rqd_pkg::OFS_REQ, 1'b1, t_req[i], s);
    wb_xfer(rqd_pkg::OFS_ID, 1'b1, t_id[i], s);
    wb_xfer(rqd_pkg::OFS_TARGET, 1'b1, t_tgt[i], s);
    wb_xfer(rqd_pkg::OFS_DATA0, 1'b1, 32'h600d0000 | 32'(i), s);
    wb_xfer(rqd_pkg::OFS_DATA1, 1'b1, 32'hd00d0000 | 32'(i), s);
    wb_xfer(rqd_pkg::OFS_CTRL, 1'b1, t_ctrl[i] | 32'h1, s);
    while (pkts !== 8'(i + 1)) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    check("desc_lo", desc[63:0], d[63:0]);
    check("desc_hi", desc[127:64], d[127:64]);
    check("masks", masks, t_ctrl[i][5] ? 8'h00 : {t_req[i][30:27], t_req[i][26:23]});
    check("beats", beats, t_ctrl[i][11] ? 2'h3 : 2'h2);
    if (t_ctrl[i][11]) begin
      check("data", pdata, {32'hd00d0000 | 32'(i), 32'h600d0000 | 32'(i)});
      check("keep", pkeep, d[74:64] == 11'h001 ? 2'h1 : 2'h3);
    end
    check("faults", errs, 8'h00);
    wb_xfer(rqd_pkg::OFS_STATUS, 1'b0, 32'h0, s);
    check("status", {s[15:8], s[0]}, {8'(i + 1), 1'b0});
    $display("case %0d done", i);
  endtask

  // Ceiling well above six packets plus register traffic
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("idle_out", {tvalid, tlast, tkeep, ack, side, rdat, tdata},
          {5'b00110, 8'h00, 32'h0, 64'h0});
    wb_xfer(rqd_pkg::OFS_STATUS, 1'b0, 32'h0, s);
    check("status_rst", s, 32'h0);
    wb_xfer(8'h40, 1'b1, 32'hffffffff, s);
    wb_xfer(8'h40, 1'b0, 32'h0, s);
    check("unmapped", s, 32'h0);
    wsel = 4'h2;
    wb_xfer(rqd_pkg::OFS_TARGET, 1'b1, 32'h12345678, s);
    wsel = 4'hf;
    wb_xfer(rqd_pkg::OFS_TARGET, 1'b0, 32'h0, s);
    check("sel_gate", s, 32'h00005600);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      run_case(i);
    end
    close_out();
  end
endmodule // testbench
